// ### shared/rtca_pkg.sv
// Constants shared by the calendar and alarm block: timing counts,
// register offsets, field positions, masks and reset values.
// Assumes a single 50 MHz clock and a plain strobe register port.
package rtca_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int HALF_SEC_MS     = 500;
  localparam int HALF_SEC_CYCLES = HALF_SEC_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int SLOW_CLK_HZ     = 32_768;
  localparam int SYNC_LEAD_EDGES = 32;
  localparam int SYNC_LEAD_CYCLES =
    SYNC_LEAD_EDGES * (1_000_000_000 / SLOW_CLK_HZ) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CTIME = 8'h04;
  localparam logic [7:0] OFS_CDATE = 8'h08;
  localparam logic [7:0] OFS_ATIME = 8'h0C;
  localparam logic [7:0] OFS_ADATE = 8'h10;
  localparam logic [7:0] OFS_STS   = 8'h14;
  localparam logic [7:0] OFS_MSK   = 8'h18;
  // Control bits
  localparam int CTRL_ON_BIT     = 0;
  localparam int CTRL_ALM_BIT    = 1;
  localparam int CTRL_SYNC_BIT   = 2;
  localparam int CTRL_PINIT_BIT  = 3;
  localparam int CTRL_DMATCH_BIT = 4;
  // Event bits of status and mask
  localparam int EV_ALARM = 0;
  localparam int EV_SEC   = 1;
  localparam int EV_W     = 2;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HR_U_LSB   = 24;
  localparam int MIN_U_LSB  = 16;
  localparam int SEC_U_LSB  = 8;
  localparam int HALF_BIT   = 7;
  localparam int YR_U_LSB   = 24;
  localparam int MON_U_LSB  = 16;
  localparam int DAY_U_LSB  = 8;
  localparam int WDAY_LSB   = 0;
  // Implemented bits of each word
  localparam logic [31:0] TIME_MASK  = 32'h3F7F_7F00;
  localparam logic [31:0] ADATE_MASK = 32'h001F_3F07;
  localparam logic [31:0] CDATE_MASK = 32'hFF1F_3F07;
  // Reset values
  localparam logic [31:0] CTIME_RST = 32'h0000_0000;
  localparam logic [31:0] CDATE_RST = 32'h0001_0106;
  localparam logic [31:0] ALARM_RST = 32'h0000_0000;
  localparam logic [4:0]  CTRL_RST  = 5'h00;
endpackage

// ### verilog/rtca_tick_gen.sv
// Half-second prescaler: an enable pulse for seconds, the half-second phase level,
// plus the update-imminent window ahead of each seconds update.
// Assumes run and restart come from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module rtca_tick_gen #(
  parameter int HALF_CNT = rtca_pkg::HALF_SEC_CYCLES,
  parameter int LEAD_CNT = rtca_pkg::SYNC_LEAD_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic run,
  input  wire logic restart,
  output logic      sec_tick,
  output logic      half_phase,
  output logic      near_upd
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        phase;
  } rtca_tick_state_type;
  rtca_tick_state_type s_q, s_d;
  logic wrap;

  // Count cycles, flip phase each half second
  always_comb begin
    s_d  = s_q;
    wrap = run && (s_q.cnt == 32'(HALF_CNT - 1));
    if (restart) begin
      s_d.cnt   = '0;
      s_d.phase = 1'b0;
    end else if (wrap) begin
      s_d.cnt   = '0;
      s_d.phase = ~s_q.phase;
    end else if (run) begin
      s_d.cnt = s_q.cnt + 32'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Seconds update on the second half-second wrap
  assign sec_tick   = wrap && s_q.phase && !restart;
  assign half_phase = s_q.phase;
  assign near_upd   = run && s_q.phase &&
                      (s_q.cnt >= 32'(HALF_CNT - LEAD_CNT));
endmodule // rtca_tick_gen
`default_nettype wire

// ### verilog/rtca_cal_next.sv
// Next-second value of the time and date words, BCD throughout.
// Purely combinational; the caller decides when to take it.
`timescale 1ns/1ps
`default_nettype none
module rtca_cal_next (
  input  wire logic [31:0] cur_time,
  input  wire logic [31:0] cur_date,
  output logic      [31:0] nxt_time,
  output logic      [31:0] nxt_date
);
  import rtca_pkg::*;

  // decimal digit carry
  // Two-digit BCD step: {carry, value}
  function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] last,
                                          input logic [7:0] first);
    if (v == last) begin
      return {1'b1, first};
    end else if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      return {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  logic [8:0] sec_s, min_s, hr_s, day_s, mon_s, yr_s;
  logic [7:0] dim;
  logic       leap;

  // Leap years: in 2000-2099, any year divisible by four
  always_comb begin
    leap = ((cur_date[YR_U_LSB +: 2] + {cur_date[YR_U_LSB + 4], 1'b0})
            == 2'b00);
    unique case (cur_date[MON_U_LSB +: 5])
      5'h02:                      dim = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: dim = 8'h30;
      default:                    dim = 8'h31;
    endcase
  end

  // Digit carries from seconds up to years
  always_comb begin
    sec_s = bcd_step({1'b0, cur_time[SEC_U_LSB +: 7]}, 8'h59, 8'h00);
    min_s = bcd_step({1'b0, cur_time[MIN_U_LSB +: 7]}, 8'h59, 8'h00);
    hr_s  = bcd_step({2'b00, cur_time[HR_U_LSB +: 6]}, 8'h23, 8'h00);
    day_s = bcd_step({2'b00, cur_date[DAY_U_LSB +: 6]}, dim, 8'h01);
    mon_s = bcd_step({3'b000, cur_date[MON_U_LSB +: 5]}, 8'h12, 8'h01);
    yr_s  = bcd_step(cur_date[YR_U_LSB +: 8], 8'h99, 8'h00);
    nxt_time = cur_time & TIME_MASK;
    nxt_date = cur_date & CDATE_MASK;
    nxt_time[SEC_U_LSB +: 7] = sec_s[6:0];
    if (sec_s[8]) nxt_time[MIN_U_LSB +: 7] = min_s[6:0];
    if (sec_s[8] && min_s[8]) nxt_time[HR_U_LSB +: 6] = hr_s[5:0];
    if (sec_s[8] && min_s[8] && hr_s[8]) begin
      nxt_date[DAY_U_LSB +: 6] = day_s[5:0];
      nxt_date[WDAY_LSB +: 3] = (cur_date[WDAY_LSB +: 3] == 3'd6) ?
                                3'd0 : cur_date[WDAY_LSB +: 3] + 3'd1;
      if (day_s[8]) nxt_date[MON_U_LSB +: 5] = mon_s[4:0];
      if (day_s[8] && mon_s[8]) nxt_date[YR_U_LSB +: 8] = yr_s[7:0];
    end
  end
endmodule // rtca_cal_next
`default_nettype wire

// ### verilog/rtca_top.sv
// Calendar clock with alarm time/date registers, alarm match,
// alarm pulse output and a masked sticky interrupt.
// Assumes one 50 MHz clock and a strobe-based register master that
// never asserts read and write strobes together.
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Alarm time keeps hours tens in 29-28 and hours units in 27-24.
// - Alarm time keeps minutes tens in 22-20 and units in 19-16.
// - Alarm time keeps seconds tens in 14-12 and units in 11-8.
// - Alarm date keeps day tens in 13-12 and day units in 11-8.
// - Alarm date keeps weekday in 2-0 and bits 7-3 read zero.
// - Two modes exist, plain calendar counting and alarm matching.
// - The calendar runs 2000 to 2099 with automatic leap years.
// - Hours are only kept in 24-hour form.
// - Time is set to whole seconds, with a readable half-second bit.
// - Every digit of time and date is its own BCD field of up to 4 bits.
// - Each alarm match sets the alarm status and toggles the pulse; the interrupt follows only when unmasked.
module rtca_top #(
  parameter int HALF_CNT = rtca_pkg::HALF_SEC_CYCLES,
  parameter int LEAD_CNT = rtca_pkg::SYNC_LEAD_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  output logic             irq,
  output logic             alarm_pulse
);
  import rtca_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              on;
    logic              alm_en;
    logic              pulse_init;
    logic              date_match;
    logic [31:0]       ctime;
    logic [31:0]       cdate;
    logic [31:0]       atime;
    logic [31:0]       adate;
    logic [EV_W-1:0]   sts;
    logic [EV_W-1:0]   msk;
    logic [31:0]       rdata;
    logic              irq;
    logic              pulse;
  } rtca_top_state_type;

  rtca_top_state_type s_q, s_d;

  logic        sec_tick;
  logic        half_phase;
  logic        near_upd;
  logic        sec_wr;
  logic [31:0] nxt_time;
  logic [31:0] nxt_date;
  logic        alm_match;
  logic        time_eq;
  logic        date_eq;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  // Write decode helper
  function automatic logic wr_hit(input logic [7:0] ofs);
    return wr_en && (addr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Prescaler and next-second calendar
  // ----------------------------------------------------------------
  // seconds write restarts prescaler
  assign sec_wr = wr_hit(OFS_CTIME);

  rtca_tick_gen #(
    .HALF_CNT (HALF_CNT),
    .LEAD_CNT (LEAD_CNT)
  ) u_tick (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .run        (s_q.on),
    .restart    (sec_wr),
    .sec_tick   (sec_tick),
    .half_phase (half_phase),
    .near_upd   (near_upd)
  );

  rtca_cal_next u_next (
    .cur_time (s_q.ctime),
    .cur_date (s_q.cdate),
    .nxt_time (nxt_time),
    .nxt_date (nxt_date)
  );

  // ----------------------------------------------------------------
  // Alarm match
  // ----------------------------------------------------------------
  // matching only in alarm mode
  always_comb begin
    time_eq   = (nxt_time & TIME_MASK) == s_q.atime;
    date_eq   = (nxt_date & ADATE_MASK) == s_q.adate;
    alm_match = sec_tick && s_q.alm_en && time_eq &&
                (date_eq || !s_q.date_match);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d    = s_q;
    ev_set = '0;
    ev_clr = '0;
    ev_set[EV_ALARM] = alm_match;
    ev_set[EV_SEC]   = sec_tick;
    if (sec_tick) begin
      s_d.ctime = nxt_time;
      s_d.cdate = nxt_date;
    end
    // pulse toggles per match, preset outside alarm mode
    if (!s_q.alm_en) begin
      s_d.pulse = s_q.pulse_init;
    end else if (alm_match) begin
      s_d.pulse = ~s_q.pulse;
    end
    // Control word
    if (wr_hit(OFS_CTRL)) begin
      s_d.on         = wr_data[CTRL_ON_BIT];
      s_d.alm_en     = wr_data[CTRL_ALM_BIT];
      s_d.pulse_init = wr_data[CTRL_PINIT_BIT];
      s_d.date_match = wr_data[CTRL_DMATCH_BIT];
    end
    // time word holds BCD digits, writes win over the tick
    if (sec_wr) begin
      s_d.ctime = wr_data & TIME_MASK;
    end
    if (wr_hit(OFS_CDATE)) begin
      s_d.cdate = wr_data & CDATE_MASK;
    end
    if (wr_hit(OFS_ATIME)) begin
      s_d.atime = wr_data & TIME_MASK;
    end
    if (wr_hit(OFS_ADATE)) begin
      s_d.adate = wr_data & ADATE_MASK;
    end
    if (wr_hit(OFS_MSK)) begin
      s_d.msk = wr_data[EV_W-1:0];
    end
    // Sticky status: write one clears, a new event wins
    if (wr_hit(OFS_STS)) begin
      ev_clr = wr_data[EV_W-1:0];
    end
    s_d.sts = (s_q.sts & ~ev_clr) | ev_set;
    s_d.irq = |(s_d.sts & s_d.msk);
    // Read data, one cycle after the strobe, zero when idle
    s_d.rdata = '0;
    if (rd_en) begin
      unique case (addr)
        OFS_CTRL: begin
          s_d.rdata[CTRL_ON_BIT]     = s_q.on;
          s_d.rdata[CTRL_ALM_BIT]    = s_q.alm_en;
          s_d.rdata[CTRL_SYNC_BIT]   = near_upd;
          s_d.rdata[CTRL_PINIT_BIT]  = s_q.pulse_init;
          s_d.rdata[CTRL_DMATCH_BIT] = s_q.date_match;
        end
        OFS_CTIME: begin
          s_d.rdata = s_q.ctime;
          s_d.rdata[HALF_BIT] = half_phase;
        end
        OFS_CDATE: s_d.rdata = s_q.cdate;
        OFS_ATIME: s_d.rdata = s_q.atime;
        OFS_ADATE: s_d.rdata = s_q.adate;
        OFS_STS:   s_d.rdata[EV_W-1:0] = s_q.sts;
        OFS_MSK:   s_d.rdata[EV_W-1:0] = s_q.msk;
        default:   s_d.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q            <= '0;
      s_q.on         <= CTRL_RST[CTRL_ON_BIT];
      s_q.alm_en     <= CTRL_RST[CTRL_ALM_BIT];
      s_q.pulse_init <= CTRL_RST[CTRL_PINIT_BIT];
      s_q.date_match <= CTRL_RST[CTRL_DMATCH_BIT];
      s_q.ctime      <= CTIME_RST;
      s_q.cdate      <= CDATE_RST;
      s_q.atime      <= ALARM_RST;
      s_q.adate      <= ALARM_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign rd_data     = s_q.rdata;
  assign irq         = s_q.irq;
  assign alarm_pulse = s_q.pulse;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence s_atime_wr_rd;
    (wr_en && addr == OFS_ATIME) ##1
    (rd_en && addr == OFS_ATIME && !wr_en);
  endsequence

  sequence s_adate_wr_rd;
    (wr_en && addr == OFS_ADATE) ##1
    (rd_en && addr == OFS_ADATE && !wr_en);
  endsequence

  sequence s_alarm_hit;
    alm_match && !(wr_en && addr == OFS_CTRL);
  endsequence

  sequence s_year_end;
    sec_tick && !wr_en && s_q.ctime == 32'h2359_5900 &&
    s_q.cdate[31:8] == 24'h9912_31;
  endsequence

  sequence s_day_end;
    sec_tick && !wr_en && s_q.ctime == 32'h2359_5900;
  endsequence

  a_atime_store: assert property (
    s_atime_wr_rd |=> rd_data == ($past(wr_data, 2) & TIME_MASK))
    else $error("alarm time readback differs from written fields");

  a_atime_rsvd: assert property (
    (rd_en && addr == OFS_ATIME) |=> (rd_data & ~TIME_MASK) == 32'h0000_0000)
    else $error("alarm time unused bits read nonzero");

  a_adate_rsvd: assert property (
    (rd_en && addr == OFS_ADATE) |=> (rd_data & ~ADATE_MASK) == 32'h0000_0000)
    else $error("alarm date unused bits read nonzero");

  // no match out of alarm mode
  a_mode_gate: assert property (
    !s_q.alm_en |-> !alm_match ##1 !$rose(s_q.sts[EV_ALARM]))
    else $error("alarm event raised while alarm mode off");

  a_pulse_toggle: assert property (
    s_alarm_hit |=> (alarm_pulse != $past(alarm_pulse)) &&
                    s_q.sts[EV_ALARM] ##1 irq == s_q.msk[EV_ALARM])
    else $error("alarm match did not toggle pulse or set status");

  a_year_wrap: assert property (
    s_year_end |=> s_q.cdate[31:8] == 24'h0001_01 &&
                   s_q.ctime == 32'h0000_0000)
    else $error("year end did not roll over to first of January");

  a_hour_wrap: assert property (
    s_day_end |=> s_q.ctime[31:8] == 24'h0000_00)
    else $error("hours did not wrap from 23 to 00");

  a_half_reset: assert property (
    sec_wr |=> !half_phase && s_q.ctime == ($past(wr_data) & TIME_MASK))
    else $error("seconds write did not restart the half second");

  // seconds units below 9 step up by one
  a_bcd_digit: assert property (
    (sec_tick && s_q.ctime[SEC_U_LSB +: 4] <= 4'h8 && !wr_en) |=>
      s_q.ctime[SEC_U_LSB +: 4] == $past(s_q.ctime[SEC_U_LSB +: 4]) + 4'h1)
    else $error("seconds units did not step by one");

  a_irq_level: assert property (
    irq == |(s_q.sts & s_q.msk))
    else $error("interrupt out of step with masked status");

  a_adate_store: assert property (
    s_adate_wr_rd |=> rd_data == ($past(wr_data, 2) & ADATE_MASK))
    else $error("alarm date readback differs from written fields");

  // leap year February reaches the 29th
  a_leap_day: assert property (
    (s_day_end ##0 (s_q.cdate[31:8] == 24'h0002_28)) |=>
      s_q.cdate[31:8] == 24'h0002_29)
    else $error("leap year February did not reach the 29th");

  // plain February ends on the 28th
  a_feb_plain: assert property (
    (s_day_end ##0 (s_q.cdate[31:8] == 24'h0102_28)) |=>
      s_q.cdate[31:8] == 24'h0103_01)
    else $error("plain year February did not roll to March");

  // weekday wraps from 6 to 0
  a_wday_wrap: assert property (
    (s_day_end ##0 (s_q.cdate[WDAY_LSB +: 3] == 3'd6)) |=>
      s_q.cdate[WDAY_LSB +: 3] == 3'd0)
    else $error("weekday did not wrap from 6 to 0");

  // seconds wrap from 59 to 00
  a_sec_wrap: assert property (
    (sec_tick && !wr_en && s_q.ctime[SEC_U_LSB +: 7] == 7'h59) |=>
      s_q.ctime[SEC_U_LSB +: 7] == 7'h00)
    else $error("seconds did not wrap from 59 to 00");

  a_hour_range: assert property (
    (sec_tick && !wr_en && s_q.ctime[HR_U_LSB +: 6] <= 6'h23) |=>
      s_q.ctime[HR_U_LSB +: 6] <= 6'h23)
    else $error("hours left the 24-hour range");

  // pulse held at its preset outside alarm mode
  a_pulse_preset: assert property (
    !s_q.alm_en |=> alarm_pulse == $past(s_q.pulse_init))
    else $error("alarm pulse left its preset outside alarm mode");

  // pulse only moves on a match
  a_pulse_quiet: assert property (
    (s_q.alm_en && !alm_match) |=> $stable(alarm_pulse))
    else $error("alarm pulse moved without an alarm match");
endmodule // rtca_top
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the calendar and alarm block.
// Assumes rtca_pkg is compiled first; a short prescaler count is used.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("Error %0t: got %h expected %h", $time, got, exp); \
  end \
end

module tb;
  import rtca_pkg::*;
  localparam int HC = 20;
  logic        ref_clk = 1'b0;
  logic        srst    = 1'b1;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wr_data = 32'h0000_0000;
  logic        wr_en   = 1'b0;
  logic        rd_en   = 1'b0;
  logic [31:0] rd_data;
  logic        irq;
  logic        alarm_pulse;
  int          num_errors = 0;
  int          checks     = 0;
  logic [31:0] seed = 32'h6ba3_5158;
  logic [31:0] v, r;
  logic        p0, seen;
  logic [31:0] ct [4], cd [4], et [4], ed [4];

  // ----------------------------------------------------------------
  // Clock, device and helpers
  // ----------------------------------------------------------------
  always #10 ref_clk = ~ref_clk;

  rtca_top #(.HALF_CNT(HC), .LEAD_CNT(4)) rtca_top_inst (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .addr        (addr),
    .wr_data     (wr_data),
    .wr_en       (wr_en),
    .rd_en       (rd_en),
    .rd_data     (rd_data),
    .irq         (irq),
    .alarm_pulse (alarm_pulse)
  );

  // Xorshift source, fixed start
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    d = rd_data;
  endtask

  // Write then read back, strobes with no gap between them
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
    @(posedge ref_clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
    rd_en   <= 1'b1;
    @(posedge ref_clk);
    rd_en   <= 1'b0;
    @(negedge ref_clk);
    q = rd_data;
  endtask

  // Expected word once unused bits are dropped
  function automatic logic [31:0] keep(input logic [31:0] d,
                                       input logic [31:0] m);
    return d & m;
  endfunction

  // Poll current time until its seconds change
  task automatic wait_sec(input logic [31:0] t0);
    seen = 1'b0;
    for (int k = 0; k < 100; k++) begin
      rd(OFS_CTIME, r);
      if (r[7]) seen = 1'b1;
      if (r[14:8] != t0[14:8]) break;
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (30000) @(posedge ref_clk);
    num_errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    ct = '{32'h2359_5900, 32'h2359_5900, 32'h2359_5900, 32'h0959_5900};
    cd = '{32'h0002_2801, 32'h0102_2803, 32'h9912_3106, 32'h0505_1502};
    et = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h1000_0000};
    ed = '{32'h0002_2902, 32'h0103_0104, 32'h0001_0100, 32'h0505_1502};
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    // Reset values and an unmapped place
    rd(OFS_ATIME, r); `CHK(r, ALARM_RST) // reset value
    rd(OFS_ADATE, r); `CHK(r, ALARM_RST) // reset value
    rd(OFS_CDATE, r); `CHK(r, CDATE_RST) // start date
    rd(OFS_CTRL, r); `CHK(r, 32'h0000_0000) // stopped, no update due
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, r); `CHK(r, 32'h0000_0000) // unmapped reads zero
    $display("test reset done");
    // Alarm registers: all ones first, then random words
    for (int i = 0; i < 16; i++) begin
      v = (i == 0) ? 32'hFFFF_FFFF : xs();
      wr_rd(OFS_ATIME, v, r); `CHK(r, keep(v, TIME_MASK))
      v = (i == 0) ? 32'hFFFF_FFFF : xs();
      wr_rd(OFS_ADATE, v, r); `CHK(r, keep(v, ADATE_MASK))
    end
    $display("test alarm fields done");
    // Half-second bit cannot be written
    wr(OFS_CTIME, 32'h0000_0080);
    rd(OFS_CTIME, r); `CHK(r, 32'h0000_0000) // half bit read-only
    // Rollovers: leap day, plain February, century, hour carry
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, 32'h0000_0000);
      wr(OFS_CDATE, cd[i]);
      wr(OFS_CTIME, ct[i]);
      wr(OFS_CTRL, 32'h0000_0001);
      wait_sec(ct[i]);
      `CHK(r, et[i]) // time rollover
      `CHK(seen, 1'b1) // half second visible
      rd(OFS_CDATE, r); `CHK(r, ed[i]) // date rollover
    end
    $display("test calendar done");
    // Alarm match with interrupt unmasked
    wr(OFS_CTRL, 32'h0000_0008);
    rd(OFS_CTRL, r); `CHK(r, 32'h0000_0008) // mode bits read back
    repeat (2) @(negedge ref_clk);
    `CHK(alarm_pulse, 1'b1) // pulse initial level
    wr(OFS_STS, 32'h0000_0003);
    wr(OFS_MSK, 32'h0000_0001);
    wr(OFS_ATIME, 32'h1200_0100);
    wr(OFS_ADATE, 32'h0000_0000);
    wr(OFS_CTIME, 32'h1200_0000);
    wr(OFS_CTRL, 32'h0000_0003);
    repeat (2) @(negedge ref_clk);
    p0 = alarm_pulse;
    wait_sec(32'h1200_0000);
    `CHK(irq, 1'b1) // interrupt on match
    `CHK(alarm_pulse, ~p0) // pulse toggles
    rd(OFS_STS, r); `CHK(r[0], 1'b1) // sticky status
    wr(OFS_STS, 32'h0000_0001);
    repeat (2) @(negedge ref_clk);
    `CHK(irq, 1'b0) // cleared by writing one
    // Same match with the interrupt masked
    wr(OFS_MSK, 32'h0000_0000);
    wr(OFS_CTIME, 32'h1200_0000);
    wait_sec(32'h1200_0000);
    `CHK(irq, 1'b0) // masked interrupt stays low
    `CHK(alarm_pulse, p0) // second toggle
    rd(OFS_STS, r); `CHK(r[0], 1'b1) // status still set
    // Date must match as well when asked; writes land after a tick
    wr(OFS_STS, 32'h0000_0003);
    wr(OFS_CTRL, 32'h0000_0013);
    wr(OFS_CTIME, 32'h1200_0000);
    wait_sec(32'h1200_0000);
    rd(OFS_STS, r); `CHK(r[0], 1'b0) // date differs, no match
    wr(OFS_ADATE, 32'h0505_1502);
    wr(OFS_CTIME, 32'h1200_0000);
    wait_sec(32'h1200_0000);
    rd(OFS_STS, r); `CHK(r[0], 1'b1) // time and date match
    $display("test alarm done");
    // Calendar mode only: no match, seconds event still raised
    wr(OFS_STS, 32'h0000_0003);
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_CTIME, 32'h1200_0000);
    wait_sec(32'h1200_0000);
    // Update-imminent flag seen while the clock runs
    seen = 1'b0;
    for (int k = 0; k < 40; k++) begin
      rd(OFS_CTRL, r);
      if (r[2]) seen = 1'b1;
    end
    `CHK(seen, 1'b1) // update-imminent visible
    wr(OFS_CTRL, 32'h0000_0000);
    rd(OFS_STS, r); `CHK(r[1:0], 2'b10) // no alarm outside mode
    wr(OFS_MSK, 32'h0000_0002);
    repeat (2) @(negedge ref_clk);
    `CHK(irq, 1'b1) // seconds event unmasked
    wr(OFS_STS, 32'h0000_0002);
    repeat (2) @(negedge ref_clk);
    `CHK(irq, 1'b0) // seconds event cleared
    $display("test modes done");
    test_done();
  end
endmodule // tb
`default_nettype wire
